// ---- cbp_dev_end.sv ----
// Clock buffer control: straps, power-down sequencing, output gating, bus
// Functional notes
// R1: Frequency strap low 133.33, high 100.00
// R2: Output frequency equals input, ratio one
// R3: Frequency change applied glitch free
// R4: Two tri-level straps give nine addresses
// R5: Straps latched at power-good assertion
// R6: Later, power-good low means power-down
// R7: Outputs disabled before oscillator turned off
// R8: Host drops power-good before stopping clock
// R9: Two low samples, hi-z at falling edge
// R10: Gating by power, enable bits, OE pin
// R11: Locked outputs within 1.8 ms
// R12: Outputs restart within 300 us
// R13: Bandwidth strap picks low, bypass, high
// R14: Bypass routes input straight to outputs
// R15: Byte 0 bits 7:6 report mode
// R16: Override bits 2:1 active when bit 3
// R17: Readback always shows latched strap mode
// R18: Warm reset needed after mode override; code applies the override without a reset
// R19: Bus runs standard mode 100 kbps
// R20: Never hold bus line low 10 ms
// R21: General call address not answered
// R22: Power-down releases bus, keeps registers
// R23: Power-down synchronised on output clock
`timescale 1ns/1ps
`include "cbp_map.svh"
module cbp_dev_end import cbp_pkg::*; #(
	parameter int LOCK_CYCLES = `CBP_LOCK_US * `CBP_REF_MHZ - 1,
	parameter int RESTART_CYCLES = `CBP_RESTART_US * `CBP_REF_MHZ - 1,
	parameter int HOLD_CYCLES =
		`CBP_HOLD_MS * `CBP_US_PER_MS * `CBP_REF_MHZ - 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	cbp_link_if.dev link,
	output logic diffClkOut,
	output logic [`CBP_NUM_OUT-1:0] diffOutEn,
	output logic feedbackClkOut,
	output logic feedbackEn,
	output logic pllOn,
	output logic bypassRoute,
	output cbp_pll_type pllMode,
	output logic freqSel,
	output logic [7:0] busAddr
);
	localparam int LOCK_W = $clog2(LOCK_CYCLES + RESTART_CYCLES + 2);
	localparam int HOLD_W = $clog2(HOLD_CYCLES + 2);

	typedef struct packed {
		logic strapped;
		logic freqSel;
		cbp_tri_type pllStrap;
		logic [7:0] busAddr;
		logic [2:0] ovr;
		logic [7:0] en0;
		logic [7:0] en1;
		logic [7:0] en2;
		logic [2:0] divCnt;
		logic [2:0] halfLen;
		logic diffClk;
		logic fbClk;
		logic pd1;
		logic pd2;
		logic pd3;
		logic offPending;
		logic outputsOff;
		logic pllOn;
		logic restart;
		logic locked;
		logic [LOCK_W-1:0] lockCnt;
		logic [`CBP_NUM_OUT-1:0] outEn;
		logic fbEn;
		cbp_pll_type mode;
		logic bypass;
		cbp_dev_smb_type smb;
		cbp_byte_type kind;
		logic rw;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic [6:0] index;
		logic sdaLow;
		logic [HOLD_W-1:0] holdCnt;
		logic sclPrev;
		logic sdaPrev;
	} cbp_dev_state_type;

	cbp_dev_state_type s;
	cbp_dev_state_type next_s;
	logic sclS, sdaS, pgS, freqS, oeS;
	logic [1:0] hiS, loS, bwS;
	logic [`CBP_NUM_OUT-1:0] enBits;
	logic [`CBP_NUM_OUT-1:0] outAllowed;
	logic divTick, diffRise, diffFall, sclRise, sclFall;
	logic startCond, stopCond, smbHold;

	cbp_sync #(.WIDTH(11)) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.asyncIn({link.scl, link.sda, link.powerGoodIn, link.freqSelStrap,
			link.oePinN, link.addrStrapHi, link.addrStrapLo,
			link.pllBwStrap}),
		.syncOut({sclS, sdaS, pgS, freqS, oeS, hiS, loS, bwS})
	);

	function automatic logic [7:0] decodeAddr(cbp_tri_type hi,
		cbp_tri_type lo);
		case ({hi, lo})
			{CBP_TRI_LOW, CBP_TRI_LOW}: decodeAddr = `CBP_ADDR_LL;
			{CBP_TRI_LOW, CBP_TRI_MID}: decodeAddr = `CBP_ADDR_LM;
			{CBP_TRI_LOW, CBP_TRI_HIGH}: decodeAddr = `CBP_ADDR_LH;
			{CBP_TRI_MID, CBP_TRI_LOW}: decodeAddr = `CBP_ADDR_ML;
			{CBP_TRI_MID, CBP_TRI_MID}: decodeAddr = `CBP_ADDR_MM;
			{CBP_TRI_MID, CBP_TRI_HIGH}: decodeAddr = `CBP_ADDR_MH;
			{CBP_TRI_HIGH, CBP_TRI_LOW}: decodeAddr = `CBP_ADDR_HL;
			{CBP_TRI_HIGH, CBP_TRI_MID}: decodeAddr = `CBP_ADDR_HM;
			default: decodeAddr = `CBP_ADDR_HH;
		endcase
	endfunction

	// Readback reflects the strap, never the override
	function automatic logic [1:0] strapCode(cbp_tri_type t);
		case (t)
			CBP_TRI_LOW: strapCode = `CBP_RB_LOW;
			CBP_TRI_MID: strapCode = `CBP_RB_BYPASS;
			default: strapCode = `CBP_RB_HIGH;
		endcase
	endfunction

	function automatic logic [7:0] readByte(cbp_dev_state_type st,
		logic oePin);
		case (st.index)
			`CBP_REG_PLL: readByte = {strapCode(st.pllStrap), 2'h0, st.ovr,
				st.freqSel}; // R15 R17
			`CBP_REG_EN0: readByte = st.en0;
			`CBP_REG_EN1: readByte = st.en1;
			`CBP_REG_OEPIN: readByte = {7'h00, oePin};
			`CBP_REG_EN2: readByte = {5'h00, st.en2[2:0]};
			default: readByte = 8'h00;
		endcase
	endfunction

	assign enBits = {s.en2[2:0], s.en1, s.en0};
	genvar gi;
	generate
		for (gi = 0; gi < `CBP_NUM_OUT; gi++) begin : g_out
			if (gi >= `CBP_OE_PIN_FIRST && gi <= `CBP_OE_PIN_LAST) begin : g_pin
				assign outAllowed[gi] = enBits[gi] && !oeS; // R10
			end else begin : g_free
				assign outAllowed[gi] = enBits[gi]; // R10
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_s.sclPrev = sclS;
		next_s.sdaPrev = sdaS;
		divTick = (s.divCnt == s.halfLen - 3'h1);
		diffRise = divTick && !s.diffClk;
		diffFall = divTick && s.diffClk;
		sclRise = sclS && !s.sclPrev;
		sclFall = !sclS && s.sclPrev;
		startCond = sclS && s.sclPrev && s.sdaPrev && !sdaS;
		stopCond = sclS && s.sclPrev && !s.sdaPrev && sdaS;
		smbHold = !s.strapped || !s.pllOn;

		// Output clock model; new ratio only taken at a half-period edge
		next_s.divCnt = s.divCnt + 3'h1;
		if (divTick) begin
			next_s.divCnt = 3'h0;
			next_s.diffClk = !s.diffClk;
			next_s.halfLen = s.freqSel ? `CBP_HALF_100 : `CBP_HALF_133; // R1 R3
		end

		if (!s.strapped) begin
			if (pgS) begin
				next_s.strapped = 1'b1; // R5
				next_s.freqSel = freqS; // R1 R2
				next_s.pllStrap = cbp_tri_type'(bwS); // R13
				next_s.busAddr = decodeAddr(cbp_tri_type'(hiS),
					cbp_tri_type'(loS)); // R4
				next_s.pllOn = 1'b1;
				next_s.outputsOff = 1'b0;
				next_s.pd1 = 1'b1;
				next_s.pd2 = 1'b1;
				next_s.pd3 = 1'b1;
			end
		end else begin
			if (diffRise) begin
				next_s.pd1 = pgS; // R6 R23
				next_s.pd2 = s.pd1;
				next_s.pd3 = s.pd2;
			end
			if (!s.pd2 && !s.pd3 && !s.outputsOff && s.pllOn) begin
				next_s.offPending = 1'b1; // R9
			end
			if (s.offPending && diffFall) begin
				next_s.offPending = 1'b0;
				next_s.outputsOff = 1'b1; // R9
			end
			// Oscillator stops only once every output is seen off
			if (s.outputsOff && !s.fbEn && !(|s.outEn)) begin
				next_s.pllOn = 1'b0; // R7
			end
			if (s.outputsOff && !s.pllOn && s.pd2) begin
				next_s.outputsOff = 1'b0;
				next_s.pllOn = 1'b1;
				next_s.restart = 1'b1; // R12
				next_s.locked = 1'b0;
				next_s.lockCnt = '0;
			end
		end
		if (s.pllOn && !s.locked) begin
			next_s.lockCnt = s.lockCnt + 1'b1;
			if (s.lockCnt == (s.restart ? LOCK_W'(RESTART_CYCLES) :
				LOCK_W'(LOCK_CYCLES))) begin
				next_s.locked = 1'b1; // R11 R12
			end
		end
		if (s.strapped && s.locked && !s.outputsOff) begin
			next_s.outEn = outAllowed; // R10
			next_s.fbEn = 1'b1; // R10
		end else begin
			next_s.outEn = '0;
			next_s.fbEn = 1'b0;
		end
		next_s.fbClk = next_s.diffClk && next_s.fbEn;

		// Override is honoured only while its enable bit is set
		if (s.ovr[2]) begin
			case (s.ovr[1:0])
				2'h0: next_s.mode = CBP_PLL_LOW_BW; // R16
				2'h1: next_s.mode = CBP_PLL_BYPASS; // R16
				default: next_s.mode = CBP_PLL_HIGH_BW; // R16
			endcase
		end else begin
			case (s.pllStrap)
				CBP_TRI_LOW: next_s.mode = CBP_PLL_LOW_BW; // R13
				CBP_TRI_MID: next_s.mode = CBP_PLL_BYPASS; // R13
				default: next_s.mode = CBP_PLL_HIGH_BW; // R13
			endcase
		end
		next_s.bypass = (s.mode == CBP_PLL_BYPASS); // R14

		////////////////////////////////////////////////////////////////////
		// Bus slave, never stretches the clock
		if (smbHold) begin
			next_s.smb = CBP_DS_IDLE; // R22
			next_s.sdaLow = 1'b0; // R22
		end else if (startCond) begin
			next_s.smb = CBP_DS_RECV;
			next_s.kind = CBP_BY_ADDR;
			next_s.bitCnt = 4'h0;
			next_s.sdaLow = 1'b0;
		end else if (stopCond) begin
			next_s.smb = CBP_DS_IDLE;
			next_s.sdaLow = 1'b0;
		end else begin
			case (s.smb)
				CBP_DS_RECV: begin
					if (sclRise) begin
						next_s.shift = {s.shift[6:0], sdaS}; // R19
						next_s.bitCnt = s.bitCnt + 4'h1;
					end
					if (sclFall && s.bitCnt == `CBP_BYTE_BITS) begin
						next_s.smb = CBP_DS_ACK;
						next_s.sdaLow = 1'b1;
						case (s.kind)
							CBP_BY_ADDR: begin
								next_s.rw = s.shift[0];
								next_s.kind = CBP_BY_CMD;
								if (s.shift[7:1] != s.busAddr[7:1]) begin
									next_s.smb = CBP_DS_IDLE; // R21
									next_s.sdaLow = 1'b0;
								end
							end
							CBP_BY_CMD: begin
								next_s.index = s.shift[6:0];
								next_s.kind = CBP_BY_DATA;
							end
							default: begin
								next_s.index = s.index + 7'h01;
								case (s.index)
									`CBP_REG_PLL: next_s.ovr =
										s.shift[`CBP_B0_OVR_EN:`CBP_B0_OVR_LO];
									`CBP_REG_EN0: next_s.en0 = s.shift;
									`CBP_REG_EN1: next_s.en1 = s.shift;
									`CBP_REG_EN2: next_s.en2 = s.shift;
									default: next_s.en0 = s.en0;
								endcase
							end
						endcase
					end
				end
				CBP_DS_ACK: begin
					if (sclFall) begin
						next_s.sdaLow = 1'b0;
						next_s.bitCnt = 4'h0;
						next_s.smb = CBP_DS_RECV;
						if (s.rw) begin
							next_s.smb = CBP_DS_SEND;
							next_s.shift = readByte(s, oeS);
							next_s.sdaLow = !next_s.shift[7];
							next_s.bitCnt = 4'h1;
						end
					end
				end
				CBP_DS_SEND: begin
					if (sclFall) begin
						if (s.bitCnt == `CBP_BYTE_BITS) begin
							next_s.sdaLow = 1'b0;
							next_s.smb = CBP_DS_MACK;
						end else begin
							next_s.sdaLow = !s.shift[6];
							next_s.shift = {s.shift[6:0], 1'b0};
							next_s.bitCnt = s.bitCnt + 4'h1;
						end
					end
				end
				CBP_DS_MACK: begin
					if (sclRise) begin
						next_s.smb = sdaS ? CBP_DS_IDLE : CBP_DS_ACK;
						next_s.index = s.index + 7'h01;
					end
				end
				default: next_s.sdaLow = 1'b0;
			endcase
		end
		next_s.holdCnt = s.sdaLow ? s.holdCnt + 1'b1 : '0;
		if (s.holdCnt == HOLD_W'(HOLD_CYCLES)) begin
			next_s.sdaLow = 1'b0; // R20
			next_s.smb = CBP_DS_IDLE; // R20
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '0;
			s.halfLen <= `CBP_HALF_133;
			s.outputsOff <= 1'b1;
			s.en0 <= `CBP_EN_RESET;
			s.en1 <= `CBP_EN_RESET;
			s.en2 <= `CBP_EN_RESET;
			s.mode <= CBP_PLL_LOW_BW;
		end else begin
			s <= next_s;
		end
	end

	assign link.sdaDevOe = s.sdaLow;
	assign diffClkOut = s.diffClk;
	assign diffOutEn = s.outEn;
	assign feedbackClkOut = s.fbClk;
	assign feedbackEn = s.fbEn;
	assign pllOn = s.pllOn;
	assign bypassRoute = s.bypass;
	assign pllMode = s.mode;
	assign freqSel = s.freqSel;
	assign busAddr = s.busAddr;
endmodule

// ---- cbp_map.svh ----
// Offsets, field positions, reset values and timing figures of the link
`ifndef CBP_MAP_SVH
`define CBP_MAP_SVH
`define CBP_REF_MHZ 25
`define CBP_US_PER_MS 1000
`define CBP_LOCK_US 1800
`define CBP_RESTART_US 300
`define CBP_HOLD_MS 10
`define CBP_SMB_KBPS 100
`define CBP_KHZ_PER_MHZ 1000
`define CBP_QUARTERS 4
`define CBP_CLK_STOP_CYCLES 8'h10
`define CBP_NUM_OUT 19
`define CBP_OE_PIN_FIRST 5
`define CBP_OE_PIN_LAST 12
`define CBP_HALF_100 3'h4
`define CBP_HALF_133 3'h3
`define CBP_REG_PLL 7'h00
`define CBP_REG_EN0 7'h01
`define CBP_REG_EN1 7'h02
`define CBP_REG_OEPIN 7'h03
`define CBP_REG_EN2 7'h04
`define CBP_B0_OVR_EN 3
`define CBP_B0_OVR_LO 1
`define CBP_CMD_BYTE_OP 8'h80
`define CBP_RD_BIT 8'h01
`define CBP_EN_RESET 8'hFF
`define CBP_RB_LOW 2'h0
`define CBP_RB_BYPASS 2'h1
`define CBP_RB_HIGH 2'h3
`define CBP_BYTE_BITS 4'h8
`define CBP_ADDR_LL 8'hD8
`define CBP_ADDR_LM 8'hDA
`define CBP_ADDR_LH 8'hDE
`define CBP_ADDR_ML 8'hC2
`define CBP_ADDR_MM 8'hC4
`define CBP_ADDR_MH 8'hC6
`define CBP_ADDR_HL 8'hCA
`define CBP_ADDR_HM 8'hCC
`define CBP_ADDR_HH 8'hCE
`endif

// ---- cbp_pkg.sv ----
// Types shared by both ends of the clock buffer control link
package cbp_pkg;
	typedef enum logic [1:0] {CBP_TRI_LOW, CBP_TRI_MID, CBP_TRI_HIGH}
		cbp_tri_type;
	typedef enum logic [1:0] {CBP_PLL_LOW_BW, CBP_PLL_BYPASS,
		CBP_PLL_HIGH_BW} cbp_pll_type;
	typedef enum logic [2:0] {CBP_DS_IDLE, CBP_DS_RECV, CBP_DS_ACK,
		CBP_DS_SEND, CBP_DS_MACK} cbp_dev_smb_type;
	typedef enum logic [1:0] {CBP_BY_ADDR, CBP_BY_CMD, CBP_BY_DATA}
		cbp_byte_type;
	typedef enum logic [2:0] {CBP_HS_IDLE, CBP_HS_START, CBP_HS_BYTE,
		CBP_HS_STOP, CBP_HS_DONE} cbp_host_type;
endpackage

// ---- cbp_link_if.sv ----
// Board wiring between power sequencer / bus host and the clock buffer
`timescale 1ns/1ps
interface cbp_link_if import cbp_pkg::*;;
	logic sclHostOe;
	logic sdaHostOe;
	logic sdaDevOe;
	logic scl;
	logic sda;
	logic powerGoodIn;
	logic freqSelStrap;
	logic oePinN;
	logic refClkRun;
	cbp_tri_type addrStrapHi;
	cbp_tri_type addrStrapLo;
	cbp_tri_type pllBwStrap;
	// Open-drain lines with external pull-ups
	assign scl = !sclHostOe;
	assign sda = !(sdaHostOe || sdaDevOe);
	modport host (output sclHostOe, output sdaHostOe, output powerGoodIn,
		output freqSelStrap, output oePinN, output refClkRun,
		output addrStrapHi, output addrStrapLo, output pllBwStrap,
		input scl, input sda);
	modport dev (output sdaDevOe, input scl, input sda, input powerGoodIn,
		input freqSelStrap, input oePinN, input refClkRun,
		input addrStrapHi, input addrStrapLo, input pllBwStrap);
endinterface

// ---- cbp_sync.sv ----
// Two-flop synchroniser for pins entering the reference clock domain
`timescale 1ns/1ps
module cbp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} cbp_sync_state_type;
	cbp_sync_state_type s;
	cbp_sync_state_type next_s;

	always_comb begin
		next_s.s1 = asyncIn;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign syncOut = s.s2;
endmodule

// ---- cbp_host_end.sv ----
// Power sequencer and standard-mode bus master facing the clock buffer
`timescale 1ns/1ps
`include "cbp_map.svh"
module cbp_host_end import cbp_pkg::*; #(
	parameter int QUARTER_CYCLES = (`CBP_REF_MHZ * `CBP_KHZ_PER_MHZ +
		`CBP_SMB_KBPS * `CBP_QUARTERS - 1) / (`CBP_SMB_KBPS * `CBP_QUARTERS)
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	cbp_link_if.host link,
	input wire logic pgReq,
	input wire logic clkStopReq,
	input wire logic freqSelCfg,
	input wire logic oeCfgN,
	input cbp_tri_type addrHiCfg,
	input cbp_tri_type addrLoCfg,
	input cbp_tri_type pllBwCfg,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire logic cmdRead,
	input wire logic [7:0] cmdAddr,
	input wire logic [6:0] cmdIndex,
	input wire logic [7:0] cmdData,
	output logic rspValid,
	output logic [7:0] rspData,
	output logic rspNack
);
	typedef struct packed {
		cbp_host_type st;
		logic [1:0] step;
		logic [1:0] ph;
		logic [7:0] qCnt;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic readOp;
		logic [7:0] addr;
		logic [6:0] idx;
		logic [7:0] data;
		logic [7:0] rsp;
		logic nack;
		logic rspValid;
		logic sclLow;
		logic sdaLow;
		logic pgOut;
		logic [7:0] pgLowCnt;
		logic clkRun;
	} cbp_host_state_type;

	cbp_host_state_type s;
	cbp_host_state_type next_s;
	logic sdaS, tick, recv;

	cbp_sync #(.WIDTH(1)) u_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.asyncIn(link.sda),
		.syncOut(sdaS)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		next_s.rspValid = 1'b0;
		tick = (s.qCnt == 8'(QUARTER_CYCLES - 1));
		recv = s.readOp && (s.step == 2'h3);
		next_s.qCnt = tick ? 8'h00 : s.qCnt + 8'h01;
		if (tick) begin
			next_s.ph = s.ph + 2'h1;
		end

		// Power-good falls first; the clock stops only after it settles
		next_s.pgOut = pgReq && !clkStopReq;
		if (s.pgOut) begin
			next_s.pgLowCnt = 8'h00;
		end else if (s.pgLowCnt != `CBP_CLK_STOP_CYCLES) begin
			next_s.pgLowCnt = s.pgLowCnt + 8'h01;
		end
		next_s.clkRun = !(clkStopReq && !s.pgOut &&
			s.pgLowCnt == `CBP_CLK_STOP_CYCLES); // R8

		case (s.st)
			CBP_HS_IDLE: begin
				if (cmdValid) begin
					next_s.st = CBP_HS_START;
					next_s.readOp = cmdRead;
					next_s.addr = cmdAddr;
					next_s.idx = cmdIndex;
					next_s.data = cmdData;
					next_s.step = 2'h0;
					next_s.nack = 1'b0;
					next_s.shift = cmdAddr & ~`CBP_RD_BIT;
					next_s.qCnt = 8'h00;
					next_s.ph = 2'h0;
				end
			end
			CBP_HS_START: begin
				if (tick) begin
					case (s.ph)
						2'h0: next_s.sdaLow = 1'b0;
						2'h1: next_s.sclLow = 1'b0;
						2'h2: next_s.sdaLow = 1'b1;
						default: begin
							next_s.sclLow = 1'b1;
							next_s.bitCnt = 4'h0;
							next_s.st = CBP_HS_BYTE;
						end
					endcase
				end
			end
			CBP_HS_BYTE: begin
				if (tick) begin
					case (s.ph)
						2'h0: next_s.sdaLow = !recv &&
							s.bitCnt != `CBP_BYTE_BITS && !s.shift[7];
						2'h1: next_s.sclLow = 1'b0; // R19
						2'h2: begin
							if (s.bitCnt != `CBP_BYTE_BITS) begin
								next_s.shift = {s.shift[6:0], sdaS};
							end else if (!recv) begin
								next_s.nack = s.nack || sdaS;
							end
						end
						default: begin
							next_s.sclLow = 1'b1;
							next_s.bitCnt = s.bitCnt + 4'h1;
							if (s.bitCnt == `CBP_BYTE_BITS) begin
								next_s.bitCnt = 4'h0;
								next_s.step = s.step + 2'h1;
								if (s.nack || recv ||
									(!s.readOp && s.step == 2'h2)) begin
									next_s.st = CBP_HS_STOP;
									next_s.rsp = s.shift;
								end else if (s.step == 2'h0) begin
									next_s.shift = {1'b0, s.idx} |
										`CBP_CMD_BYTE_OP;
								end else if (!s.readOp) begin
									next_s.shift = s.data;
								end else if (s.step == 2'h1) begin
									next_s.st = CBP_HS_START;
									next_s.shift = s.addr | `CBP_RD_BIT;
								end else begin
									next_s.shift = 8'h00;
								end
							end
						end
					endcase
				end
			end
			CBP_HS_STOP: begin
				if (tick) begin
					case (s.ph)
						2'h0: next_s.sdaLow = 1'b1;
						2'h1: next_s.sclLow = 1'b0;
						2'h2: next_s.sdaLow = 1'b0;
						default: next_s.st = CBP_HS_DONE;
					endcase
				end
			end
			CBP_HS_DONE: begin
				next_s.rspValid = 1'b1;
				next_s.st = CBP_HS_IDLE;
			end
			default: next_s.st = CBP_HS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '0;
			s.clkRun <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign cmdReady = (s.st == CBP_HS_IDLE);
	assign rspValid = s.rspValid;
	assign rspData = s.rsp;
	assign rspNack = s.nack;
	assign link.sclHostOe = s.sclLow;
	assign link.sdaHostOe = s.sdaLow;
	assign link.powerGoodIn = s.pgOut;
	assign link.refClkRun = s.clkRun;
	assign link.freqSelStrap = freqSelCfg;
	assign link.oePinN = oeCfgN;
	assign link.addrStrapHi = addrHiCfg;
	assign link.addrStrapLo = addrLoCfg;
	assign link.pllBwStrap = pllBwCfg;
endmodule

// ---- cbp_link_sva.sv ----
// Checker on the link between power sequencer, bus host and buffer
`timescale 1ns/1ps
module cbp_link_sva #(
	parameter int HOLD_CYCLES = 2000,
	parameter int QUARTER_CYCLES = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic scl,
	input wire logic sdaDevOe,
	input wire logic powerGoodIn,
	input wire logic refClkRun
);
	localparam int SCL_LOW_MAX = 4 * QUARTER_CYCLES;
	int sdaCnt;
	int sclCnt;
	int pgLowCnt;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////
	// Run lengths; cleared in reset so a second reset starts afresh
	always_ff @(posedge ref_clk) begin
		sdaCnt <= (sdaDevOe && rst_n) ? sdaCnt + 1 : 0;
		sclCnt <= (!scl && rst_n) ? sclCnt + 1 : 0;
		pgLowCnt <= (powerGoodIn || !rst_n) ? 0 : pgLowCnt + 1;
	end
	////////////////////////////////////////////////////////////////////////
	AST_PG_BEFORE_STOP: assert property ($fell(refClkRun) |->
		!powerGoodIn && !$past(powerGoodIn, 8))
		else $error("ref clock stopped while power good high");
	AST_CLK_BEFORE_PG: assert property ($rose(powerGoodIn) |->
		refClkRun && $past(refClkRun))
		else $error("power good raised without running clock");
	AST_SDA_HOLD: assert property (sdaCnt < HOLD_CYCLES)
		else $error("device held data line too long");
	AST_PD_RELEASE: assert property (pgLowCnt >= 64 |-> !sdaDevOe)
		else $error("data line driven in power-down");
	AST_SCL_LOW_MIN: assert property ($rose(scl) |->
		sclCnt >= QUARTER_CYCLES)
		else $error("bus clock low phase too short");
	AST_SCL_LOW_MAX: assert property (sclCnt <= SCL_LOW_MAX)
		else $error("bus clock held low too long");
	AST_DEV_SDA_SCL_LOW: assert property ($changed(sdaDevOe) |-> !scl)
		else $error("device changed data while clock high");
	AST_ACK_SPANS_SCL: assert property ($rose(sdaDevOe) |->
		##[1:SCL_LOW_MAX] (scl && sdaDevOe))
		else $error("device released data before clock high");
	cover property ($fell(powerGoodIn));
	cover property ($rose(sdaDevOe));
	cover property ($fell(refClkRun));
endmodule

// ---- clock_buffer_strap_powerdown_ctrl_tb.sv ----
// Bench joining host end and device end of the clock buffer link
`timescale 1ns/1ps
`include "cbp_map.svh"
module clock_buffer_strap_powerdown_ctrl_tb import cbp_pkg::*;;
	logic ref_clk, rst_n, pgReq, clkStopReq, freqSelCfg, oeCfgN;
	cbp_tri_type addrHiCfg, addrLoCfg, pllBwCfg;
	logic cmdValid, cmdReady, cmdRead, rspValid, rspNack;
	logic [7:0] cmdAddr, cmdData, rspData, busAddr, devAddr;
	logic [6:0] cmdIndex;
	logic diffClkOut, feedbackClkOut, feedbackEn, pllOn, bypassRoute, freqSel;
	logic [18:0] diffOutEn;
	cbp_pll_type pllMode;
	int failCount, checksDone, n;
	logic [7:0] addrTab [9] = '{`CBP_ADDR_LL, `CBP_ADDR_LM, `CBP_ADDR_LH,
		`CBP_ADDR_ML, `CBP_ADDR_MM, `CBP_ADDR_MH, `CBP_ADDR_HL,
		`CBP_ADDR_HM, `CBP_ADDR_HH};
	logic [1:0] rbTab [3] = '{`CBP_RB_LOW, `CBP_RB_BYPASS, `CBP_RB_HIGH};
	cbp_link_if link();
	cbp_dev_end #(.LOCK_CYCLES(50), .RESTART_CYCLES(20), .HOLD_CYCLES(2000))
		cbp_dev_end_inst(.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
		.diffClkOut(diffClkOut), .diffOutEn(diffOutEn),
		.feedbackClkOut(feedbackClkOut), .feedbackEn(feedbackEn),
		.pllOn(pllOn), .bypassRoute(bypassRoute), .pllMode(pllMode),
		.freqSel(freqSel), .busAddr(busAddr));
	cbp_host_end #(.QUARTER_CYCLES(4)) cbp_host_end_inst(.ref_clk(ref_clk),
		.rst_n(rst_n), .link(link), .pgReq(pgReq), .clkStopReq(clkStopReq),
		.freqSelCfg(freqSelCfg), .oeCfgN(oeCfgN), .addrHiCfg(addrHiCfg),
		.addrLoCfg(addrLoCfg), .pllBwCfg(pllBwCfg), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .cmdRead(cmdRead), .cmdAddr(cmdAddr),
		.cmdIndex(cmdIndex), .cmdData(cmdData), .rspValid(rspValid),
		.rspData(rspData), .rspNack(rspNack));
	// Checker defaults already match the shortened bench timing
	cbp_link_sva cbp_link_sva_inst(
		.ref_clk(ref_clk), .rst_n(rst_n), .scl(link.scl),
		.sdaDevOe(link.sdaDevOe), .powerGoodIn(link.powerGoodIn),
		.refClkRun(link.refClkRun));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			failCount++;
			$display("BAD %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic tallyAndFinish();
		$display("TB: checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Request held from one falling edge over the rising edge that takes it
	task automatic bus(input logic r, input logic [7:0] a,
		input logic [6:0] i, input logic [7:0] d);
		for (n = 0; n < 50 && cmdReady !== 1'b1; n++) @(negedge ref_clk);
		cmdValid = 1'h1;
		cmdRead = r;
		cmdAddr = a;
		cmdIndex = i;
		cmdData = d;
		@(negedge ref_clk);
		cmdValid = 1'h0;
		for (n = 0; n < 4000 && rspValid !== 1'b1; n++) @(negedge ref_clk);
		chk(n < 4000, 1'h1);
	endtask
	task automatic wr(input logic [6:0] i, input logic [7:0] d);
		bus(1'h0, devAddr, i, d);
		chk(rspNack, 1'h0);
	endtask
	task automatic rd(input logic [6:0] i, input logic [7:0] exp);
		bus(1'h1, devAddr, i, 8'h00);
		chk(rspNack, 1'h0);
		chk(rspData, exp);
	endtask
	task automatic waitEn(output int c);
		for (c = 0; c < 200 && feedbackEn !== 1'b1; c++) @(negedge ref_clk);
	endtask
	task automatic half(output int h);
		for (n = 0; n < 20 && diffClkOut !== 1'b0; n++) @(negedge ref_clk);
		for (n = 0; n < 20 && diffClkOut !== 1'b1; n++) @(negedge ref_clk);
		for (h = 0; h < 20 && diffClkOut === 1'b1; h++) @(negedge ref_clk);
	endtask
	// Straps set before power good so the first latch sees them settled
	task automatic boot(input int i);
		rst_n = 1'h0;
		pgReq = 1'h0;
		addrHiCfg = cbp_tri_type'(i / 3);
		addrLoCfg = cbp_tri_type'(i % 3);
		pllBwCfg = cbp_tri_type'(i % 3);
		freqSelCfg = i[0];
		repeat (8) @(negedge ref_clk);
		rst_n = 1'h1;
		@(negedge ref_clk);
		pgReq = 1'h1;
		repeat (8) @(negedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'h0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		failCount++;
		tallyAndFinish();
	end
	initial begin
		{rst_n, pgReq, clkStopReq, freqSelCfg, oeCfgN, cmdValid} = 6'h00;
		{cmdRead, cmdAddr, cmdIndex, cmdData} = 24'h000000;
		{addrHiCfg, addrLoCfg, pllBwCfg} = {3{CBP_TRI_LOW}};
		for (int i = 0; i < 9; i++) begin
			boot(i);
			devAddr = addrTab[i];
			chk(busAddr, addrTab[i]);
			chk(pllMode, i % 3);
			chk(bypassRoute, i % 3 == 1);
			chk(freqSel, i[0]);
			waitEn(n);
			chk(n inside {[35:55]}, 1'h1);
			chk(diffOutEn, 19'h7FFFF);
			chk(feedbackClkOut, diffClkOut);
			half(n);
			chk(n, i[0] ? `CBP_HALF_100 : `CBP_HALF_133);
			rd(7'h00, {rbTab[i % 3], 5'h00, i[0]});
		end
		$display("TB: strap test done");
		bus(1'h0, 8'hC4, 7'h01, 8'h00);
		chk(rspNack, 1'h1);
		bus(1'h0, 8'h00, 7'h01, 8'h00);
		chk(rspNack, 1'h1);
		rd(7'h01, 8'hFF);
		wr(7'h00, 8'h02);
		chk(pllMode, CBP_PLL_HIGH_BW);
		wr(7'h00, 8'h08);
		chk(pllMode, CBP_PLL_LOW_BW);
		wr(7'h00, 8'h0A);
		// Settle time before the new mode is relied upon
		repeat (2) @(negedge ref_clk);
		chk(pllMode, CBP_PLL_BYPASS);
		chk(bypassRoute, 1'h1);
		rd(7'h00, 8'hCA);
		$display("TB: override test done");
		oeCfgN = 1'h1;
		wr(7'h01, 8'h00);
		wr(7'h02, 8'hF0);
		rd(7'h03, 8'h01);
		chk(diffOutEn, 19'h7E000);
		oeCfgN = 1'h0;
		repeat (6) @(negedge ref_clk);
		chk(diffOutEn, 19'h7F000);
		wr(7'h04, 8'h00);
		chk(diffOutEn, 19'h0F000);
		chk(feedbackEn, 1'h1);
		wr(7'h10, 8'h55);
		rd(7'h10, 8'h00);
		$display("TB: gating test done");
		addrHiCfg = CBP_TRI_LOW;
		pgReq = 1'h0;
		for (n = 0; n < 100 && feedbackEn !== 1'b0; n++) @(negedge ref_clk);
		chk(pllOn, 1'h1);
		chk(diffOutEn, 19'h00000);
		chk(feedbackClkOut, 1'h0);
		@(negedge ref_clk);
		chk(pllOn, 1'h0);
		clkStopReq = 1'h1;
		repeat (40) @(negedge ref_clk);
		chk(link.refClkRun, 1'h0);
		bus(1'h1, devAddr, 7'h01, 8'h00);
		chk(rspNack, 1'h1);
		clkStopReq = 1'h0;
		repeat (20) @(negedge ref_clk);
		pgReq = 1'h1;
		waitEn(n);
		chk(n < 60, 1'h1);
		chk(busAddr, 8'hCE);
		rd(7'h01, 8'h00);
		rd(7'h00, 8'hCA);
		$display("TB: power-down test done");
		tallyAndFinish();
	end
endmodule
